/* design/swc_pkg.sv */
`default_nettype none
package swc_pkg;
  // ==========================================================
  // Register map: printed offsets are word indexes
  localparam logic [7:0]  IDX_WAKE_CTRL    = 8'h0B;
  localparam logic [7:0]  IDX_IRQ_STATUS   = 8'h10;
  localparam logic [7:0]  IDX_IRQ_MASK     = 8'h11;
  localparam logic [31:0] ADDR_WAKE_CTRL   = 32'h0000_002C;
  localparam logic [31:0] ADDR_IRQ_STATUS  = 32'h0000_0040;
  localparam logic [31:0] ADDR_IRQ_MASK    = 32'h0000_0044;
  localparam int          ADDR_W           = 8;

  // ==========================================================
  // Wake source control fields
  localparam int BIT_STOP_FLAG   = 7;
  localparam int BIT_LEVEL       = 6;
  localparam int BIT_DELAY       = 5;
  localparam int BIT_SRC_HI      = 4;
  localparam int BIT_SRC_LO      = 2;
  localparam int BIT_SHORT_RST   = 1;
  localparam int BIT_DIV16       = 0;

  localparam logic       RST_LEVEL     = 1'b0;
  localparam logic       RST_DELAY     = 1'b1;
  localparam logic [2:0] RST_SRC       = 3'h0;
  localparam logic       RST_SHORT_RST = 1'b0;
  localparam logic       RST_DIV16     = 1'b0;

  // ==========================================================
  // Source codes
  localparam logic [2:0] SRC_NONE     = 3'h0;
  localparam logic [2:0] SRC_RESERVED = 3'h1;
  localparam logic [2:0] SRC_P3_PIN1  = 3'h2;
  localparam logic [2:0] SRC_P3_PIN2  = 3'h3;
  localparam logic [2:0] SRC_P3_PIN3  = 3'h4;
  localparam logic [2:0] SRC_P2_PIN7  = 3'h5;
  localparam logic [2:0] SRC_P2_NOR_LO = 3'h6;
  localparam logic [2:0] SRC_P2_NOR_HI = 3'h7;

  // ==========================================================
  // Interrupt status bits
  localparam int IRQ_W          = 2;
  localparam int IRQ_BIT_WAKE   = 0;
  localparam int IRQ_BIT_DONE   = 1;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS       = 40;
  localparam int POR_PERIOD_NS       = 10_000_000;
  localparam int SHORT_PERIOD_NS     = 2_500_000;
  localparam int POR_CYCLES          = POR_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SHORT_CYCLES        = (SHORT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W               = 18;
  localparam int DIV_RATIO           = 16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage
`default_nettype wire

/* design/swc_wake_select.sv */
`default_nettype none
module swc_wake_select (
  input  wire logic [7:0] port2_in,
  input  wire logic [3:0] port3_in,
  input  wire logic [7:0] port2_ignore,
  input  wire logic [3:0] port3_ignore,
  input  wire logic [2:0] src,
  input  wire logic       level,
  output logic            wake
);
  logic       sel_valid;
  logic       sel_value;
  logic [7:0] p2_used;

  // Ignored pins drop out of the NOR; a NOR with no pins left selects nothing
  assign p2_used = port2_in & ~port2_ignore;

  always_comb begin
    sel_valid = 1'b0;
    sel_value = 1'b0;
    case (src)
      swc_pkg::SRC_P3_PIN1: begin
        sel_valid = ~port3_ignore[1];
        sel_value = port3_in[1];
      end
      swc_pkg::SRC_P3_PIN2: begin
        sel_valid = ~port3_ignore[2];
        sel_value = port3_in[2];
      end
      swc_pkg::SRC_P3_PIN3: begin
        sel_valid = ~port3_ignore[3];
        sel_value = port3_in[3];
      end
      swc_pkg::SRC_P2_PIN7: begin
        sel_valid = ~port2_ignore[7];
        sel_value = port2_in[7];
      end
      swc_pkg::SRC_P2_NOR_LO: begin
        sel_valid = ~&port2_ignore[3:0];
        sel_value = ~|p2_used[3:0];
      end
      swc_pkg::SRC_P2_NOR_HI: begin
        sel_valid = ~&port2_ignore[7:4];
        sel_value = ~|p2_used[7:4];
      end
      default: begin
        sel_valid = 1'b0;
        sel_value = 1'b0;
      end
    endcase
  end

  assign wake = sel_valid & ~(sel_value ^ level);
endmodule
`default_nettype wire

/* design/swc_recovery_timer.sv */
`default_nettype none
module swc_recovery_timer #(
  parameter int POR_CYCLES   = swc_pkg::POR_CYCLES,
  parameter int SHORT_CYCLES = swc_pkg::SHORT_CYCLES
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic start,
  input  wire logic delay_en,
  input  wire logic short_en,
  input  wire logic xtal_ok,
  output logic      busy,
  output logic      done
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_XTAL, ST_COUNT} swc_tmr_state_t;

  swc_tmr_state_t                     state_ff;
  logic [swc_pkg::TMR_W-1:0]          cnt_ff;
  logic [swc_pkg::TMR_W-1:0]          limit_ff;
  logic [swc_pkg::TMR_W-1:0]          pu_cnt_ff;
  logic                               pu_done_ff;
  logic                               done_ff;

  // Time since power-up, saturating once the short period has passed
  always_ff @(posedge clk) begin
    if (srst) begin
      pu_cnt_ff  <= '0;
      pu_done_ff <= 1'b0;
    end else if (!pu_done_ff) begin
      pu_cnt_ff  <= pu_cnt_ff + 1'b1;
      pu_done_ff <= (pu_cnt_ff == swc_pkg::TMR_W'(SHORT_CYCLES - 1));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
      limit_ff <= '0;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          cnt_ff <= '0;
          if (start) begin
            if (!delay_en) begin
              done_ff <= 1'b1;
            end else if (short_en) begin
              state_ff <= ST_WAIT_XTAL;
            end else begin
              limit_ff <= swc_pkg::TMR_W'(POR_CYCLES - 1);
              state_ff <= ST_COUNT;
            end
          end
        end
        ST_WAIT_XTAL: begin
          // Oscillation alone is not enough right after power-up
          if (xtal_ok && pu_done_ff) begin
            limit_ff <= swc_pkg::TMR_W'(SHORT_CYCLES - 1);
            state_ff <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == limit_ff) begin
            state_ff <= ST_IDLE;
            done_ff  <= 1'b1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign busy = (state_ff != ST_IDLE);
  assign done = done_ff;
endmodule
`default_nettype wire

/* design/swc_top.sv */
// Design decision made here: the AXI4-Lite interface to the registers.
`default_nettype none
module swc_top #(
  parameter int POR_CYCLES   = swc_pkg::POR_CYCLES,
  parameter int SHORT_CYCLES = swc_pkg::SHORT_CYCLES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  // AXI4-Lite slave
  input  wire logic [31:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [31:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Pins and neighbouring wake logic
  input  wire logic [7:0]  PORT2_IN,
  input  wire logic [3:0]  PORT3_IN,
  input  wire logic        CRYSTAL_OSC_OK,
  input  wire logic [7:0]  PORT2_IS_OUTPUT,
  input  wire logic [3:0]  PORT3_IS_OUTPUT,
  input  wire logic [7:0]  PORT2_CHANGE_WAKE_SELECT,
  input  wire logic [3:0]  PORT3_CHANGE_WAKE_SELECT,
  input  wire logic        OTHER_WAKE,
  input  wire logic        STOP_ACTIVE,
  output logic             WAKE_EVENT,
  output logic             RECOVERY_RESET,
  output logic             CLK_TICK,
  output logic             IRQ
);
  // ==========================================================
  // Pin synchronisers
  logic [7:0] p2_meta_ff;
  logic [7:0] p2_sync_ff;
  logic [3:0] p3_meta_ff;
  logic [3:0] p3_sync_ff;
  logic       xtal_meta_ff;
  logic       xtal_sync_ff;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      p2_meta_ff   <= 8'h00;
      p2_sync_ff   <= 8'h00;
      p3_meta_ff   <= 4'h0;
      p3_sync_ff   <= 4'h0;
      xtal_meta_ff <= 1'b0;
      xtal_sync_ff <= 1'b0;
    end else begin
      p2_meta_ff   <= PORT2_IN;
      p2_sync_ff   <= p2_meta_ff;
      p3_meta_ff   <= PORT3_IN;
      p3_sync_ff   <= p3_meta_ff;
      xtal_meta_ff <= CRYSTAL_OSC_OK;
      xtal_sync_ff <= xtal_meta_ff;
    end
  end

  // ==========================================================
  // Wake source control register
  logic       level_ff;
  logic       delay_ff;
  logic [2:0] src_ff;
  logic       short_ff;
  logic       div16_ff;
  logic       stop_flag_ff;
  logic [swc_pkg::IRQ_W-1:0] status_ff;
  logic [swc_pkg::IRQ_W-1:0] mask_ff;

  logic       wr_fire;
  logic [7:0] wr_idx;
  logic [7:0] wr_byte;
  logic       sel_wake;
  logic       wake_any;
  logic       rec_start;
  logic       tmr_busy;
  logic       tmr_done;

  // A recovery restores most fields; the source field is kept
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      level_ff <= swc_pkg::RST_LEVEL;
      delay_ff <= swc_pkg::RST_DELAY;
      src_ff   <= swc_pkg::RST_SRC;
      short_ff <= swc_pkg::RST_SHORT_RST;
      div16_ff <= swc_pkg::RST_DIV16;
    end else if (rec_start) begin
      level_ff <= swc_pkg::RST_LEVEL;
      delay_ff <= swc_pkg::RST_DELAY;
      short_ff <= swc_pkg::RST_SHORT_RST;
      div16_ff <= swc_pkg::RST_DIV16;
    end else if (wr_fire && wr_idx == swc_pkg::IDX_WAKE_CTRL) begin
      level_ff <= wr_byte[swc_pkg::BIT_LEVEL];
      delay_ff <= wr_byte[swc_pkg::BIT_DELAY];
      src_ff   <= wr_byte[swc_pkg::BIT_SRC_HI:swc_pkg::BIT_SRC_LO];
      short_ff <= wr_byte[swc_pkg::BIT_SHORT_RST];
      div16_ff <= wr_byte[swc_pkg::BIT_DIV16];
    end
  end

  // Start-up flag has no write path at all
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      stop_flag_ff <= 1'b0;
    end else if (rec_start) begin
      stop_flag_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Wake detection and recovery sequencing
  swc_wake_select u_sel (
    .port2_in     (p2_sync_ff),
    .port3_in     (p3_sync_ff),
    .port2_ignore (PORT2_IS_OUTPUT | PORT2_CHANGE_WAKE_SELECT),
    .port3_ignore (PORT3_IS_OUTPUT | PORT3_CHANGE_WAKE_SELECT),
    .src          (src_ff),
    .level        (level_ff),
    .wake         (sel_wake)
  );

  assign wake_any  = sel_wake | OTHER_WAKE;
  // A short wake while the delay is off relies on the source staying active
  assign rec_start = STOP_ACTIVE & wake_any & ~tmr_busy & ~RECOVERY_RESET;

  swc_recovery_timer #(
    .POR_CYCLES   (POR_CYCLES),
    .SHORT_CYCLES (SHORT_CYCLES)
  ) u_tmr (
    .clk      (CORE_CLK),
    .srst     (SRST),
    .start    (rec_start),
    .delay_en (delay_ff),
    .short_en (short_ff),
    .xtal_ok  (xtal_sync_ff),
    .busy     (tmr_busy),
    .done     (tmr_done)
  );

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      WAKE_EVENT     <= 1'b0;
      RECOVERY_RESET <= 1'b0;
    end else begin
      WAKE_EVENT     <= wake_any;
      RECOVERY_RESET <= rec_start | (tmr_busy & ~tmr_done);
    end
  end

  // ==========================================================
  // Clock prescaler tick
  logic [3:0] div_cnt_ff;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      div_cnt_ff <= 4'h0;
      CLK_TICK   <= 1'b0;
    end else begin
      div_cnt_ff <= div16_ff ? div_cnt_ff + 4'h1 : 4'h0;
      CLK_TICK   <= div16_ff ? (div_cnt_ff == 4'(swc_pkg::DIV_RATIO - 1)) : 1'b1;
    end
  end

  // ==========================================================
  // Interrupts: set wins over write-one-to-clear
  logic [swc_pkg::IRQ_W-1:0] irq_set;
  logic [swc_pkg::IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[swc_pkg::IRQ_BIT_WAKE] = rec_start;
    irq_set[swc_pkg::IRQ_BIT_DONE] = tmr_done;
    irq_clr = (wr_fire && wr_idx == swc_pkg::IDX_IRQ_STATUS) ?
              wr_byte[swc_pkg::IRQ_W-1:0] : '0;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      status_ff <= '0;
      mask_ff   <= '0;
      IRQ       <= 1'b0;
    end else begin
      status_ff <= (status_ff & ~irq_clr) | irq_set;
      if (wr_fire && wr_idx == swc_pkg::IDX_IRQ_MASK) begin
        mask_ff <= wr_byte[swc_pkg::IRQ_W-1:0];
      end
      IRQ <= |(status_ff & mask_ff);
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  logic       aw_got_ff;
  logic       w_got_ff;
  logic [7:0] aw_idx_ff;
  logic       aw_ok_ff;
  logic [7:0] w_byte_ff;
  logic       w_lane0_ff;

  function automatic logic addr_ok(input logic [31:0] a);
    addr_ok = (a == swc_pkg::ADDR_WAKE_CTRL) || (a == swc_pkg::ADDR_IRQ_STATUS) ||
              (a == swc_pkg::ADDR_IRQ_MASK);
  endfunction

  assign wr_fire = aw_got_ff & w_got_ff & ~S_AXI_BVALID & aw_ok_ff & w_lane0_ff;
  assign wr_idx  = aw_idx_ff;
  assign wr_byte = w_byte_ff;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      aw_idx_ff     <= 8'h00;
      aw_ok_ff      <= 1'b0;
      w_byte_ff     <= 8'h00;
      w_lane0_ff    <= 1'b0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= swc_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_ff     <= 1'b1;
        aw_idx_ff     <= S_AXI_AWADDR[swc_pkg::ADDR_W+1:2];
        aw_ok_ff      <= addr_ok(S_AXI_AWADDR);
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_ff     <= 1'b1;
        w_byte_ff    <= S_AXI_WDATA[7:0];
        w_lane0_ff   <= S_AXI_WSTRB[0];
        S_AXI_WREADY <= 1'b0;
      end
      if (aw_got_ff && w_got_ff && !S_AXI_BVALID) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= aw_ok_ff ? swc_pkg::RESP_OKAY : swc_pkg::RESP_DECERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (S_AXI_ARADDR)
      swc_pkg::ADDR_WAKE_CTRL: begin
        rd_word[swc_pkg::BIT_STOP_FLAG] = stop_flag_ff;
        rd_word[swc_pkg::BIT_LEVEL]     = level_ff;
        rd_word[swc_pkg::BIT_DELAY]     = delay_ff;
        rd_word[swc_pkg::BIT_SRC_HI:swc_pkg::BIT_SRC_LO] = src_ff;
        rd_word[swc_pkg::BIT_SHORT_RST] = short_ff;
        rd_word[swc_pkg::BIT_DIV16]     = div16_ff;
      end
      swc_pkg::ADDR_IRQ_STATUS: rd_word[swc_pkg::IRQ_W-1:0] = status_ff;
      swc_pkg::ADDR_IRQ_MASK:   rd_word[swc_pkg::IRQ_W-1:0] = mask_ff;
      default:                  rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= swc_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_word;
      S_AXI_RRESP   <= addr_ok(S_AXI_ARADDR) ? swc_pkg::RESP_OKAY : swc_pkg::RESP_DECERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* sim/swc_pin_model.sv */
`default_nettype none
module swc_pin_model #(
  parameter int HOLD     = 10,
  parameter int XTAL_DLY = 5
) (
  input  wire logic       clk,
  input  wire logic [7:0] p2_cmd,
  input  wire logic [3:0] p3_cmd,
  input  wire logic       osc_on,
  output logic      [7:0] port2_in,
  output logic      [3:0] port3_in,
  output logic            osc_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold_ff = 0;
  int osc_ff  = 0;

  initial begin
    port2_in = 8'h00;
    port3_in = 4'h0;
    osc_ok   = 1'b0;
  end

  // ==========
  // A new level stays long enough for a fast recovery to see it
  always @(posedge clk) begin
    if (hold_ff > 0) begin
      hold_ff <= hold_ff - 1;
    end else if ({p2_cmd, p3_cmd} != {port2_in, port3_in}) begin
      port2_in <= p2_cmd;
      port3_in <= p3_cmd;
      hold_ff  <= HOLD;
    end
  end

  // ==========
  // Crystal amplitude is only reported some clocks after start-up
  always @(posedge clk) begin
    osc_ff <= osc_on ? osc_ff + 1 : 0;
    osc_ok <= osc_on && (osc_ff >= XTAL_DLY);
  end
endmodule
`default_nettype wire

/* sim/swc_top_monitor.sv */
`default_nettype none
module swc_top_monitor #(
  parameter int POR_CYCLES = swc_pkg::POR_CYCLES
) (
  input wire logic        CORE_CLK,
  input wire logic        SRST,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        OTHER_WAKE,
  input wire logic        STOP_ACTIVE,
  input wire logic        WAKE_EVENT,
  input wire logic        RECOVERY_RESET,
  input wire logic        CLK_TICK,
  input wire logic        IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SRST);

  // ==========
  // Length of the recovery reset in progress
  logic [31:0] rr_len_ff;
  logic [31:0] nxt_rr_len;
  assign nxt_rr_len = RECOVERY_RESET ? rr_len_ff + 32'h0000_0001 : 32'h0000_0000;
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rr_len_ff <= 32'h0000_0000;
    end else begin
      rr_len_ff <= nxt_rr_len;
    end
  end

  // ==========
  // Register bus
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_wr_answer;
    !S_AXI_AWREADY && !S_AXI_WREADY ##1 S_AXI_BVALID;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write response not on time");
  a_ctrl_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
    S_AXI_ARADDR == swc_pkg::ADDR_WAKE_CTRL |=> S_AXI_RVALID && S_AXI_RRESP == 2'h0
    && S_AXI_RDATA[31:8] == 24'h00_0000) else $error("control read wrong");
  a_hole_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
    S_AXI_ARADDR == 32'h0000_0030 |=> S_AXI_RRESP == 2'h3 && S_AXI_RDATA == 32'h0000_0000)
    else $error("unmapped read not refused");

  // ==========
  // Wake and recovery
  a_other_wake: assert property (OTHER_WAKE |=> WAKE_EVENT)
    else $error("other wake source lost");
  a_recovery_cause: assert property ($rose(RECOVERY_RESET) |-> WAKE_EVENT && $past(STOP_ACTIVE))
    else $error("recovery without wake in stop");
  a_recovery_len: assert property (rr_len_ff <= POR_CYCLES + 4)
    else $error("recovery reset too long");
  a_irq_source: assert property ($rose(IRQ) |-> $past(RECOVERY_RESET) || $past(RECOVERY_RESET, 2))
    else $error("interrupt without recovery");
  a_tick_returns: assert property (!CLK_TICK |-> ##[1:15] CLK_TICK)
    else $error("clock enable gap over 16");
  a_reset_quiet: assert property (disable iff (1'b0) SRST |=> !WAKE_EVENT && !RECOVERY_RESET
    && !IRQ && S_AXI_AWREADY && !S_AXI_BVALID) else $error("outputs active after reset");
endmodule

bind swc_top swc_top_monitor #(.POR_CYCLES(POR_CYCLES)) swc_top_monitor_i (
  .CORE_CLK, .SRST, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
  .S_AXI_BVALID, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
  .S_AXI_RRESP, .S_AXI_RVALID, .OTHER_WAKE, .STOP_ACTIVE, .WAKE_EVENT,
  .RECOVERY_RESET, .CLK_TICK, .IRQ);
`default_nettype wire

/* sim/stop_wake_source_control_test.sv */
`default_nettype none
`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module stop_wake_source_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR   = 20;
  localparam int SHORT = 8;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, stop = 1'b0, oth = 1'b0, osc = 1'b0;
  logic [31:0] aw = 32'h0000_0000, wd = 32'h0000_0000, ar = 32'h0000_0000, rd, data;
  logic [7:0]  p2 = 8'h00, p2o = 8'h00, p2c = 8'h00, p2_pin;
  logic [3:0]  p3 = 4'h0, p3o = 4'h0, p3c = 4'h0, p3_pin;
  logic        awr, wr, bv, arr, rv, xok, wake, rrst, tick, irq;
  logic [1:0]  br, rr, resp;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          len;

  always #20 clk = ~clk;

  swc_pin_model #(.HOLD(10), .XTAL_DLY(5)) swc_pin_model_i (.clk(clk), .p2_cmd(p2),
    .p3_cmd(p3), .osc_on(osc), .port2_in(p2_pin), .port3_in(p3_pin), .osc_ok(xok));

  swc_top #(.POR_CYCLES(POR), .SHORT_CYCLES(SHORT)) swc_top_i (.CORE_CLK(clk), .SRST(srst),
    .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(1'b1), .PORT2_IN(p2_pin), .PORT3_IN(p3_pin), .CRYSTAL_OSC_OK(xok),
    .PORT2_IS_OUTPUT(p2o), .PORT3_IS_OUTPUT(p3o), .PORT2_CHANGE_WAKE_SELECT(p2c),
    .PORT3_CHANGE_WAKE_SELECT(p3c), .OTHER_WAKE(oth), .STOP_ACTIVE(stop),
    .WAKE_EVENT(wake), .RECOVERY_RESET(rrst), .CLK_TICK(tick), .IRQ(irq));

  // ==========
  // Bus access
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    aw  <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    // No bound of its own: only the watchdog may end a stalled write
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    resp = br;
  endtask

  task automatic axr(input logic [31:0] a);
    ar  <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    data = rd;
    resp = rr;
  endtask

  task automatic recover();
    stop <= 1'b1;
    for (int n = 0; n < 50 && rrst !== 1'b1; n++) @(posedge clk);
    stop <= 1'b0;
    len = 0;
    for (int n = 0; n < 500 && rrst === 1'b1; n++) begin
      @(posedge clk);
      len++;
    end
  endtask

  function automatic logic exp_wake(logic [2:0] s, logic lv, logic [7:0] a, logic [3:0] b);
    logic v;
    case (s)
      3'h2: v = b[1];
      3'h3: v = b[2];
      3'h4: v = b[3];
      3'h5: v = a[7];
      3'h6: v = ~|a[3:0];
      3'h7: v = ~|a[7:4];
      default: return 1'b0;
    endcase
    return v == lv;
  endfunction

  task automatic give_verdict();
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Whole run needs a few hundred clocks
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    osc  <= 1'b1;
    @(posedge clk);
    axr(swc_pkg::ADDR_WAKE_CTRL);
    `CHK(data, 32'h0000_0020)
    `CHK(resp, 2'h0)
    axw(swc_pkg::ADDR_WAKE_CTRL, 32'h0000_00FF);
    axr(swc_pkg::ADDR_WAKE_CTRL);
    `CHK(data, 32'h0000_007F)
    len = 0;
    repeat (32) begin @(posedge clk); len += tick; end
    `CHK(len, 2)
    axw(swc_pkg::ADDR_WAKE_CTRL, 32'h0000_0020);
    len = 0;
    repeat (32) begin @(posedge clk); len += tick; end
    `CHK(len, 32)
    axr(32'h0000_0030);
    `CHK({resp, data}, {2'h3, 32'h0000_0000})
    axw(32'h0000_0030, 32'h0000_00FF);
    `CHK(resp, 2'h3)
    for (int pat = 0; pat < 2; pat++) begin
      p2 <= pat ? 8'h0F : 8'h80;
      p3 <= pat ? 4'hC : 4'h2;
      repeat (16) @(posedge clk);
      for (int c = 0; c < 16; c++) begin
        axw(swc_pkg::ADDR_WAKE_CTRL, {25'h000_0000, c[0], 1'b1, c[3:1], 2'h0});
        repeat (4) @(posedge clk);
        `CHK(wake, exp_wake(c[3:1], c[0], p2, p3))
      end
    end
    axw(swc_pkg::ADDR_WAKE_CTRL, 32'h0000_0078);
    p2 <= 8'h01;
    repeat (16) @(posedge clk);
    `CHK(wake, 1'b0)
    p2c <= 8'h01;
    repeat (4) @(posedge clk);
    `CHK(wake, 1'b1)
    p2c <= 8'h00;
    p2o <= 8'h01;
    repeat (4) @(posedge clk);
    `CHK(wake, 1'b1)
    p2o <= 8'h00;
    p3  <= 4'h2;
    p3o <= 4'h2;
    axw(swc_pkg::ADDR_WAKE_CTRL, 32'h0000_0068);
    repeat (16) @(posedge clk);
    `CHK(wake, 1'b0)
    p3o <= 4'h0;
    p3c <= 4'h2;
    repeat (4) @(posedge clk);
    `CHK(wake, 1'b0)
    p3c <= 4'h0;
    axw(swc_pkg::ADDR_WAKE_CTRL, 32'h0000_0020);
    oth <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(wake, 1'b1)
    oth <= 1'b0;
    axw(swc_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
    axw(swc_pkg::ADDR_WAKE_CTRL, 32'h0000_0069);
    recover();
    `CHK(len >= POR, 1'b1)
    axr(swc_pkg::ADDR_WAKE_CTRL);
    `CHK(data, 32'h0000_00A8)
    `CHK(irq, 1'b1)
    axr(swc_pkg::ADDR_IRQ_STATUS);
    `CHK(data, 32'h0000_0003)
    axw(swc_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    axw(swc_pkg::ADDR_WAKE_CTRL, 32'h0000_0048);
    recover();
    `CHK(len, 1)
    axw(swc_pkg::ADDR_WAKE_CTRL, 32'h0000_006A);
    recover();
    `CHK(len >= SHORT && len < POR, 1'b1)
    axw(swc_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
    axw(swc_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    axw(swc_pkg::ADDR_WAKE_CTRL, 32'h0000_0068);
    recover();
    axr(swc_pkg::ADDR_IRQ_STATUS);
    `CHK({irq, data}, {1'b0, 32'h0000_0003})
    // A power-on class reset clears the kept source field and the flag
    srst <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    axr(swc_pkg::ADDR_WAKE_CTRL);
    `CHK(data, 32'h0000_0020)
    give_verdict();
  end
endmodule
`default_nettype wire
